// [logic/rpn_cfg.svh]
// limits, defaults and number format of the numeric entry and stack unit
`ifndef RPN_CFG_SVH
`define RPN_CFG_SVH

// --------------------------------------------------------------------
// entry limits
// --------------------------------------------------------------------
`define RPN_MANT_MAX_CHARS 4'd12
`define RPN_DEFAULT_MANT 40'd1
`define RPN_SHIFT_BLANK 3'd5

// --------------------------------------------------------------------
// stack and number format
// --------------------------------------------------------------------
`define RPN_STACK_DEPTH 5
`define RPN_NORM_LO 40'd1000
`define RPN_NORM_HI 40'd9999
`define RPN_PRE_HI 40'd99999
`define RPN_EXP_MAX 10'sd127
`define RPN_MANT_BIG 16'h270f
`define RPN_LETTER_MAX 10'sd12
`define RPN_STAR_MAX 10'sd99

// --------------------------------------------------------------------
// arithmetic
// --------------------------------------------------------------------
`define RPN_ALIGN_LIM 40'd1000000000
`define RPN_DIV_SCALE 40'd100000000
`define RPN_DIV_SHIFT 10'sd8

`endif

// [logic/rpn_pkg.sv]
// shared types of the numeric entry and stack unit
package rpn_pkg;

	// key commands from the keyboard, numbered in this order from 0
	typedef enum logic [4:0] {
		KEY_DIGIT, KEY_POINT, KEY_SIGN_TOGGLE, KEY_EXPONENT_ENTRY,
		KEY_ENTER, KEY_DROP_ENTRY, KEY_SHIFT, KEY_CLEAR_SHIFT,
		KEY_RUN, KEY_STEP, KEY_STOP, KEY_PAUSE,
		KEY_ADD, KEY_SUB, KEY_MUL, KEY_DIV, KEY_WFM_REF, KEY_OTHER
	} rpn_key_e;

	// one stack level: constant m * 10^e, or waveform reference in mant
	typedef struct packed {
		logic sign;
		logic is_ref;
		logic [15:0] mant;
		logic signed [7:0] exp;
	} rpn_num_s;

endpackage

// [logic/rpn_arith.sv]
// sequential two-operand arithmetic on normalized stack values
`timescale 1ns/10ps
`include "rpn_cfg.svh"

module rpn_arith import rpn_pkg::*; #(
	parameter int MW = 40
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// request: a is the second register, b the entry register
	input wire logic go,
	input wire rpn_key_e op,
	input wire rpn_num_s a,
	input wire rpn_num_s b,
	// result, not yet normalized
	output logic done,
	output logic div_zero,
	output logic r_sign,
	output logic [MW-1:0] r_mant,
	output logic signed [9:0] r_exp
);

	typedef enum {A_IDLE, A_ALIGN} rpn_ast_e;

	rpn_ast_e st_r;
	logic sa_r, sb_r;
	logic [MW-1:0] ma_r, mb_r;
	logic signed [9:0] ea_r, eb_r;

	// --------------------------------------------------------------------
	// operand preparation
	// --------------------------------------------------------------------
	wire [MW-1:0] ma_in = MW'(a.mant);
	wire [MW-1:0] mb_in = MW'(b.mant);
	wire signed [9:0] ea_in = (a.mant == 16'h0000) ? 10'(b.exp) : 10'(a.exp);
	wire signed [9:0] eb_in = (b.mant == 16'h0000) ? 10'(a.exp) : 10'(b.exp);
	// subtract is add with the entry operand's sign turned round
	wire sb_in = b.sign ^ (op == KEY_SUB);
	wire a_ge_b = ma_r >= mb_r;

	// --------------------------------------------------------------------
	// sequencer: multiply and divide in one step, add aligns first
	// --------------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= A_IDLE;
			sa_r <= 1'b0;
			sb_r <= 1'b0;
			ma_r <= '0;
			mb_r <= '0;
			ea_r <= '0;
			eb_r <= '0;
			done <= 1'b0;
			div_zero <= 1'b0;
			r_sign <= 1'b0;
			r_mant <= '0;
			r_exp <= '0;
		end else begin
			done <= 1'b0;
			div_zero <= 1'b0;
			case (st_r)
				A_IDLE: begin
					if (go) begin
						sa_r <= a.sign;
						sb_r <= sb_in;
						ma_r <= ma_in;
						mb_r <= mb_in;
						ea_r <= ea_in;
						eb_r <= eb_in;
						if (op == KEY_MUL) begin
							done <= 1'b1;
							r_sign <= a.sign ^ b.sign;
							r_mant <= MW'(ma_in * mb_in);
							r_exp <= 10'(a.exp) + 10'(b.exp);
						end else if (op == KEY_DIV) begin
							done <= 1'b1;
							r_sign <= a.sign ^ b.sign;
							div_zero <= (mb_in == '0);
							// scaling the dividend by 10^8 keeps at least eight digits of quotient
							r_mant <= (mb_in == '0) ? '0 :
								MW'((ma_in * `RPN_DIV_SCALE) / mb_in);
							r_exp <= 10'(a.exp) - 10'(b.exp) - `RPN_DIV_SHIFT;
						end else begin
							st_r <= A_ALIGN;
						end
					end
				end
				A_ALIGN: begin
					if (ea_r == eb_r) begin
						done <= 1'b1;
						st_r <= A_IDLE;
						r_exp <= ea_r;
						if (sa_r == sb_r) begin
							r_mant <= ma_r + mb_r;
							r_sign <= sa_r;
						end else begin
							r_mant <= a_ge_b ? ma_r - mb_r : mb_r - ma_r;
							r_sign <= a_ge_b ? sa_r : sb_r;
						end
					end else if (ea_r > eb_r) begin
						// grow the larger-exponent side first, lose digits last
						if (ma_r < `RPN_ALIGN_LIM) begin
							ma_r <= MW'(ma_r * 40'd10);
							ea_r <= ea_r - 10'sd1;
						end else begin
							mb_r <= mb_r / 40'd10;
							eb_r <= eb_r + 10'sd1;
						end
					end else begin
						if (mb_r < `RPN_ALIGN_LIM) begin
							mb_r <= MW'(mb_r * 40'd10);
							eb_r <= eb_r - 10'sd1;
						end else begin
							ma_r <= ma_r / 40'd10;
							ea_r <= ea_r + 10'sd1;
						end
					end
				end
				default: st_r <= A_IDLE;
			endcase
		end
	end

endmodule

// [logic/rpn_entry_stack.sv]
// keystroke numeric entry, rounding and five-level operand stack
//
// What this block does
// - numbers enter only via the entry register, keys taken in order
// - a second decimal point in the mantissa is dropped with a warning
// - mantissa holds at most 12 characters; extras dropped, each warned
// - mantissa sign starts positive; each sign toggle inverts it
// - mantissa entry ends on exponent, ENTER or non-numeric terminating keys only
// - exponent key with no mantissa gives default mantissa 1
// - exponent keeps only the two most recent digits
// - point or repeated exponent key in exponent entry warns, ignored
// - exponent sign starts positive; toggles invert exponent sign only
// - exponent entry ends on ENTER or a non-numeric terminating key
// - entry and divide-by-zero warnings are a flag, no text message
// - at entry end mantissa rounds to four digits, 1.000 to 999.9
// - exponent shown as a letter between ten to minus 12 and plus 12
// - shift in entry blanks 5 characters, shows marker, value kept
// - drop pops the stack instead of writing zero
// - ENTER ends the number and separates it from the next
// - a function key runs at once unless the unit is busy
// - two-operand functions pop twice then push one result
// - add puts second plus entry register into entry register
// - subtract gives second minus entry register
// - multiply gives entry times second register
// - divide gives second over entry; zero divisor warns, saturates
// - stack is five levels each holding a constant or a reference
// - pop delivers entry level, copies higher levels down, top kept
// - digits after a function start a new number, pushing the old
`timescale 1ns/10ps
`include "rpn_cfg.svh"

module rpn_entry_stack import rpn_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// keyboard
	input wire logic key_valid,
	input wire rpn_key_e key_code,
	input wire logic [3:0] key_digit,
	// dispatcher
	output logic busy,
	output logic warn,
	output logic cmd_valid,
	output rpn_key_e cmd_code,
	// entry field
	output logic entry_active,
	output logic entry_in_exp,
	output logic entry_sign,
	output logic [39:0] entry_mant,
	output logic [7:0] entry_exp_digits,
	output logic entry_exp_sign,
	output logic shift_mark,
	output logic [2:0] blank_chars,
	// entry and second register contents
	output rpn_num_s x_val,
	output rpn_num_s y_val,
	// entry register readout
	output logic signed [9:0] disp_exp,
	output logic [1:0] disp_lead,
	output logic disp_letter,
	output logic disp_stars,
	output logic disp_tiny
);

	typedef enum {ST_IDLE, ST_MANT, ST_EXP, ST_NORM, ST_EXEC,
		ST_ALU} rpn_st_e;

	// floor of a signed value divided by three
	function automatic logic signed [9:0] rpn_fl3(
		input logic signed [9:0] t);
		logic signed [9:0] q;
		q = t / 10'sd3;
		if (t < 10'sd0 && q * 10'sd3 != t)
			q = q - 10'sd1;
		return q;
	endfunction

	rpn_st_e st_r;
	rpn_key_e pend_r;
	logic [3:0] pend_dig_r;
	logic [3:0] chars_r, frac_r;
	logic point_r, any_r, merge_r;
	logic n_sign_r;
	logic [39:0] n_mant_r;
	logic signed [9:0] n_exp_r;
	rpn_num_s stk_r [`RPN_STACK_DEPTH];
	logic alu_go_r;
	logic alu_done, alu_dz, alu_sign;
	logic [39:0] alu_mant;
	logic signed [9:0] alu_exp;

	// --------------------------------------------------------------------
	// key decoding
	// --------------------------------------------------------------------
	wire in_entry = (st_r == ST_MANT) || (st_r == ST_EXP);
	// a pending command replays through the same path as a fresh key
	wire act_valid = (st_r == ST_EXEC) || (key_valid && st_r == ST_IDLE);
	wire rpn_key_e act_code = (st_r == ST_EXEC) ? pend_r : key_code;
	wire [3:0] act_dig = (st_r == ST_EXEC) ? pend_dig_r : key_digit;
	wire k_num = key_code == KEY_DIGIT || key_code == KEY_POINT ||
		key_code == KEY_EXPONENT_ENTRY;
	wire k_run = key_code == KEY_RUN || key_code == KEY_STEP ||
		key_code == KEY_STOP || key_code == KEY_PAUSE;
	wire k_keep = k_run || key_code == KEY_SIGN_TOGGLE ||
		key_code == KEY_SHIFT || key_code == KEY_CLEAR_SHIFT;
	wire k_end = key_valid && in_entry && !k_num && !k_keep;
	wire a_arith = act_code == KEY_ADD || act_code == KEY_SUB ||
		act_code == KEY_MUL || act_code == KEY_DIV;
	wire a_fwd = act_code == KEY_RUN || act_code == KEY_STEP ||
		act_code == KEY_STOP || act_code == KEY_PAUSE ||
		act_code == KEY_OTHER;
	wire refs = stk_r[0].is_ref || stk_r[1].is_ref;
	wire full = chars_r == `RPN_MANT_MAX_CHARS;

	// --------------------------------------------------------------------
	// exponent value at the end of entry
	// --------------------------------------------------------------------
	wire [9:0] exp_mag = 10'(entry_exp_digits[7:4]) * 10'd10 +
		10'(entry_exp_digits[3:0]);
	wire signed [9:0] term_exp = (entry_exp_sign ? -$signed(exp_mag) :
		$signed(exp_mag)) - $signed(10'(frac_r));

	// --------------------------------------------------------------------
	// entry register readout, exponent kept a multiple of three
	// --------------------------------------------------------------------
	wire signed [9:0] x_lead = 10'(stk_r[0].exp) + 10'sd3;
	wire signed [9:0] x_dexp = rpn_fl3(x_lead) * 10'sd3;
	wire x_zero = stk_r[0].mant == 16'h0000;

	// --------------------------------------------------------------------
	// normalized value ready to store, too large saturated to the exponent range, too small flushed to zero
	// --------------------------------------------------------------------
	wire n_big = n_exp_r > `RPN_EXP_MAX;
	wire n_small = n_exp_r < -`RPN_EXP_MAX;
	wire n_fit = n_mant_r >= `RPN_NORM_LO && n_mant_r <= `RPN_NORM_HI;
	wire rpn_num_s n_val = '{sign: n_sign_r, is_ref: 1'b0,
		mant: n_small ? 16'h0000 : (n_big ? `RPN_MANT_BIG : n_mant_r[15:0]),
		exp: n_big ? 8'(`RPN_EXP_MAX) :
			(n_small ? 8'sh00 : n_exp_r[7:0])};

	rpn_arith #(
		.MW(40)
	) u_arith (
		.clk(clk),
		.sys_rst(sys_rst),
		.go(alu_go_r),
		.op(pend_r),
		.a(stk_r[1]),
		.b(stk_r[0]),
		.done(alu_done),
		.div_zero(alu_dz),
		.r_sign(alu_sign),
		.r_mant(alu_mant),
		.r_exp(alu_exp)
	);

	// --------------------------------------------------------------------
	// readout registers follow the entry and second registers and the shift marker one cycle later
	// --------------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			disp_exp <= '0;
			disp_lead <= 2'h0;
			disp_letter <= 1'b0;
			disp_stars <= 1'b0;
			disp_tiny <= 1'b0;
			x_val <= '0;
			y_val <= '0;
			blank_chars <= 3'h0;
		end else begin
			disp_exp <= x_dexp;
			disp_lead <= 2'(x_lead - x_dexp);
			disp_letter <= x_dexp >= -`RPN_LETTER_MAX &&
				x_dexp <= `RPN_LETTER_MAX;
			disp_stars <= !x_zero && x_lead > `RPN_STAR_MAX + 10'sd1;
			disp_tiny <= !x_zero && x_lead <= -`RPN_STAR_MAX + 10'sd1;
			x_val <= stk_r[0];
			y_val <= stk_r[1];
			blank_chars <= shift_mark ? `RPN_SHIFT_BLANK : 3'h0;
		end
	end

	// --------------------------------------------------------------------
	// command sequencer and stack
	// --------------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= ST_IDLE;
			pend_r <= KEY_ENTER;
			pend_dig_r <= 4'h0;
			chars_r <= 4'h0;
			frac_r <= 4'h0;
			point_r <= 1'b0;
			any_r <= 1'b0;
			merge_r <= 1'b0;
			n_sign_r <= 1'b0;
			n_mant_r <= '0;
			n_exp_r <= '0;
			for (int i = 0; i < `RPN_STACK_DEPTH; i++)
				stk_r[i] <= '0;
			alu_go_r <= 1'b0;
			busy <= 1'b0;
			warn <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_code <= KEY_OTHER;
			entry_active <= 1'b0;
			entry_in_exp <= 1'b0;
			entry_sign <= 1'b0;
			entry_mant <= '0;
			entry_exp_digits <= 8'h00;
			entry_exp_sign <= 1'b0;
			shift_mark <= 1'b0;
		end else begin
			warn <= 1'b0;
			cmd_valid <= 1'b0;
			alu_go_r <= 1'b0;
			// idle and pending-command actions
			if (act_valid) begin
				st_r <= ST_IDLE;
				if (act_code == KEY_DIGIT || act_code == KEY_POINT ||
					act_code == KEY_EXPONENT_ENTRY) begin
					// a new number always pushes the previous one up
					for (int i = `RPN_STACK_DEPTH - 1; i > 0; i--)
						stk_r[i] <= stk_r[i-1];
					entry_active <= 1'b1;
					entry_sign <= 1'b0;
					entry_exp_sign <= 1'b0;
					entry_exp_digits <= 8'h00;
					frac_r <= 4'h0;
					point_r <= act_code == KEY_POINT;
					any_r <= act_code == KEY_DIGIT;
					chars_r <= (act_code == KEY_EXPONENT_ENTRY) ? 4'h0 : 4'h1;
					entry_mant <= (act_code == KEY_DIGIT) ? 40'(act_dig) :
						((act_code == KEY_POINT) ? '0 : `RPN_DEFAULT_MANT);
					entry_in_exp <= act_code == KEY_EXPONENT_ENTRY;
					st_r <= (act_code == KEY_EXPONENT_ENTRY) ? ST_EXP : ST_MANT;
				end else if (act_code == KEY_SIGN_TOGGLE) begin
					stk_r[0].sign <= !stk_r[0].sign;
				end else if (act_code == KEY_DROP_ENTRY) begin
					for (int i = 0; i < `RPN_STACK_DEPTH - 1; i++)
						stk_r[i] <= stk_r[i+1];
				end else if (act_code == KEY_WFM_REF) begin
					for (int i = `RPN_STACK_DEPTH - 1; i > 0; i--)
						stk_r[i] <= stk_r[i-1];
					stk_r[0] <= '{sign: 1'b0, is_ref: 1'b1,
						mant: 16'(act_dig), exp: 8'sh00};
				end else if (a_arith && !refs) begin
					pend_r <= act_code;
					alu_go_r <= 1'b1;
					busy <= 1'b1;
					st_r <= ST_ALU;
				end else if (a_fwd || a_arith) begin
					// waveform math and other commands go to the dispatcher
					cmd_valid <= 1'b1;
					cmd_code <= act_code;
				end
				if (st_r == ST_EXEC && !a_arith)
					busy <= 1'b0;
			end
			case (st_r)
				ST_MANT, ST_EXP: begin
					if (k_end) begin
						n_sign_r <= entry_sign;
						n_mant_r <= entry_mant;
						n_exp_r <= term_exp;
						merge_r <= 1'b0;
						pend_r <= key_code;
						pend_dig_r <= key_digit;
						// exponent phase ends with the number, so later keys
						// are not taken for exponent keys
						entry_in_exp <= 1'b0;
						entry_active <= 1'b0;
						busy <= 1'b1;
						st_r <= ST_NORM;
					end else if (key_valid) begin
						case (key_code)
							KEY_DIGIT: begin
								if (st_r == ST_EXP) begin
									entry_exp_digits <= {entry_exp_digits[3:0],
										key_digit};
								end else if (full) begin
									warn <= 1'b1;
								end else begin
									entry_mant <= 40'(entry_mant * 40'd10) +
										40'(key_digit);
									chars_r <= chars_r + 4'h1;
									frac_r <= frac_r + {3'h0, point_r};
									any_r <= 1'b1;
								end
							end
							KEY_POINT: begin
								if (st_r == ST_EXP || point_r || full) begin
									warn <= 1'b1;
								end else begin
									point_r <= 1'b1;
									chars_r <= chars_r + 4'h1;
								end
							end
							KEY_EXPONENT_ENTRY: begin
								if (st_r == ST_EXP) begin
									warn <= 1'b1;
								end else begin
									if (!any_r)
										entry_mant <= `RPN_DEFAULT_MANT;
									entry_in_exp <= 1'b1;
									st_r <= ST_EXP;
								end
							end
							KEY_SIGN_TOGGLE: begin
								if (st_r == ST_EXP)
									entry_exp_sign <= !entry_exp_sign;
								else
									entry_sign <= !entry_sign;
							end
							KEY_SHIFT: shift_mark <= 1'b1;
							KEY_CLEAR_SHIFT: shift_mark <= 1'b0;
							KEY_RUN, KEY_STEP, KEY_STOP, KEY_PAUSE: begin
								cmd_valid <= 1'b1;
								cmd_code <= key_code;
							end
							default: ;
						endcase
					end
				end
				ST_NORM: begin
					// one decade per cycle, rounding only on the last one
					if (n_mant_r == '0) begin
						n_exp_r <= '0;
						n_mant_r <= `RPN_NORM_LO;
						n_sign_r <= 1'b0;
						stk_r[0] <= '0;
						st_r <= merge_r ? ST_IDLE : ST_EXEC;
					end else if (n_mant_r > `RPN_PRE_HI) begin
						n_mant_r <= n_mant_r / 40'd10;
						n_exp_r <= n_exp_r + 10'sd1;
					end else if (n_mant_r > `RPN_NORM_HI) begin
						n_mant_r <= (n_mant_r + 40'd5) / 40'd10;
						n_exp_r <= n_exp_r + 10'sd1;
					end else if (!n_fit) begin
						n_mant_r <= 40'(n_mant_r * 40'd10);
						n_exp_r <= n_exp_r - 10'sd1;
					end else begin
						stk_r[0] <= n_val;
						st_r <= merge_r ? ST_IDLE : ST_EXEC;
					end
					if (st_r == ST_NORM && merge_r && (n_mant_r == '0 || n_fit))
						busy <= 1'b0;
				end
				ST_ALU: begin
					if (alu_done) begin
						// two pops and one push leave W copied into T
						for (int i = 1; i < `RPN_STACK_DEPTH - 1; i++)
							stk_r[i] <= stk_r[i+1];
						n_sign_r <= alu_sign;
						n_mant_r <= alu_mant;
						n_exp_r <= alu_exp;
						merge_r <= 1'b1;
						if (alu_dz) begin
							warn <= 1'b1;
							n_mant_r <= 40'(`RPN_MANT_BIG);
							n_exp_r <= `RPN_EXP_MAX;
						end
						st_r <= ST_NORM;
					end
				end
				default: ;
			endcase
		end
	end

endmodule

// [bench/rpn_es_properties.sv]
// concurrent checks on the ports of the numeric entry and stack unit
`timescale 1ns/10ps
module rpn_es_properties import rpn_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// keyboard
	input wire logic key_valid,
	input wire rpn_key_e key_code,
	// watched outputs
	input wire logic busy,
	input wire logic warn,
	input wire logic cmd_valid,
	input wire logic entry_active,
	input wire logic entry_in_exp,
	input wire logic entry_sign,
	input wire logic [39:0] entry_mant,
	input wire logic entry_exp_sign,
	input wire logic shift_mark,
	input wire logic [2:0] blank_chars,
	input wire rpn_num_s x_val,
	input wire rpn_num_s y_val,
	input wire logic signed [9:0] disp_exp,
	input wire logic disp_letter
);
	// one clock domain, so one default clock and reset
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// a key the unit really takes: busy keys are dropped silently
	wire take = key_valid && !busy;
	wire tgl = take && key_code == KEY_SIGN_TOGGLE;

	a_warn_has_cause: assert property (warn |->
		$past(key_valid) || $past(busy))
		else $error("warn without a key or operation");
	a_cmd_has_cause: assert property (cmd_valid |->
		$past(take) || $past(busy))
		else $error("command pulse without a key");
	a_mant_toggle: assert property (tgl && entry_active && !entry_in_exp |=>
		entry_sign != $past(entry_sign)) else $error("mantissa sign kept");
	a_exp_toggle: assert property (tgl && entry_in_exp |=>
		entry_exp_sign != $past(entry_exp_sign) && $stable(entry_sign))
		else $error("exponent toggle wrong");
	a_blank_follow: assert property (blank_chars ==
		($past(shift_mark) ? 3'h5 : 3'h0)) else $error("blank count wrong");
	a_shift_keeps: assert property (take && key_code == KEY_SHIFT &&
		entry_active |=> shift_mark && $stable(entry_mant))
		else $error("shift changed value");
	a_exp_default: assert property (take && key_code == KEY_EXPONENT_ENTRY &&
		!entry_active |=> entry_in_exp && entry_mant == 40'h1)
		else $error("default mantissa missing");
	a_exp_point_warn: assert property (take && entry_in_exp &&
		key_code == KEY_POINT |=> warn) else $error("no warn on point");
	a_mant_range: assert property (x_val.is_ref || x_val.mant == 16'h0 ||
		(x_val.mant >= 16'h03e8 && x_val.mant <= 16'h270f))
		else $error("mantissa not normalized");
	a_letter_range: assert property (disp_letter |-> disp_exp >= -10'sh00c
		&& disp_exp <= 10'sh00c) else $error("letter out of range");
	a_drop_pop: assert property (take && key_code == KEY_DROP_ENTRY &&
		!entry_active |-> ##2 x_val == $past(y_val)) else $error("drop wrong");
	a_busy_bound: assert property ($rose(busy) |-> ##[1:600] !busy)
		else $error("busy too long");
endmodule

// [bench/rpn_kbd_model.sv]
// keyboard model: one strobed key code at a time, never while busy
`timescale 1ns/10ps
module rpn_kbd_model import rpn_pkg::*; (
	// clock and busy of the unit
	input wire logic clk,
	input wire logic busy,
	// key lines
	output logic key_valid,
	output rpn_key_e key_code,
	output logic [3:0] key_digit,
	// raised when the unit never becomes free
	output logic hang
);
	// idle lines from time zero
	initial begin
		key_valid = 1'b0;
		key_code = KEY_OTHER;
		key_digit = 4'h0;
		hang = 1'b0;
	end

	// waits out busy, then strobes for exactly one cycle at falling edges
	task automatic press(input rpn_key_e c, input logic [3:0] d);
		int n;
		n = 0;
		@(negedge clk);
		while (busy !== 1'b0 && n < 2000) begin
			n++;
			@(negedge clk);
		end
		hang = (n >= 2000);
		key_code = c;
		key_digit = d;
		key_valid = 1'b1;
		@(negedge clk);
		key_valid = 1'b0;
		key_code = KEY_OTHER;
		key_digit = ~d; // released lines must not keep the old digit
	endtask
endmodule

// [bench/rpn_entry_stack_tb.sv]
// self-checking bench of the numeric entry and stack unit
`timescale 1ns/10ps
module rpn_entry_stack_tb import rpn_pkg::*; ();
	logic clk, sys_rst, key_valid, hang, w;
	rpn_key_e key_code, cmd_code;
	logic [3:0] key_digit;
	logic busy, warn, cmd_valid, entry_active, entry_in_exp, entry_sign;
	logic entry_exp_sign, shift_mark, disp_letter, disp_stars, disp_tiny;
	logic [39:0] entry_mant;
	logic [7:0] entry_exp_digits;
	logic [2:0] blank_chars;
	logic [1:0] disp_lead;
	logic signed [9:0] disp_exp;
	rpn_num_s x_val, y_val;
	int err_total = 0;
	int n_tests = 0;

	// --------------------------------------------------------------
	// unit and keyboard
	// --------------------------------------------------------------
	rpn_entry_stack i_dut (.clk, .sys_rst, .key_valid, .key_code,
		.key_digit, .busy, .warn, .cmd_valid, .cmd_code, .entry_active,
		.entry_in_exp, .entry_sign, .entry_mant, .entry_exp_digits,
		.entry_exp_sign, .shift_mark, .blank_chars, .x_val, .y_val,
		.disp_exp, .disp_lead, .disp_letter, .disp_stars, .disp_tiny);
	rpn_kbd_model i_kbd (.clk, .busy, .key_valid, .key_code, .key_digit,
		.hang);

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic chk(input logic [39:0] seen, input logic [39:0] want);
		n_tests++;
		if (seen !== want) begin
			err_total++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// keys a small integer digit by digit
	task automatic num(input int v);
		if (v >= 100) i_kbd.press(KEY_DIGIT, 4'(v / 100));
		if (v >= 10) i_kbd.press(KEY_DIGIT, 4'((v / 10) % 10));
		i_kbd.press(KEY_DIGIT, 4'(v % 10));
	endtask

	// waits until free, noting any warn on the way; x_val lags one cycle
	task automatic idle(output logic wr);
		int n;
		wr = warn;
		n = 0;
		while (busy !== 1'b0 && n < 2000) begin
			@(negedge clk);
			wr = wr | warn;
			n++;
		end
		repeat (2) begin
			@(negedge clk);
			wr = wr | warn;
		end
		if (n >= 2000) begin
			err_total++;
			complete_run();
		end
	endtask

	// a stuck unit ends the run
	always @(posedge hang) begin
		err_total++;
		complete_run();
	end

	// operand, function, operand, expected result
	typedef struct {
		int a;
		rpn_key_e op;
		int b;
		logic [25:0] r;
	} rpn_row_s;
	rpn_row_s rows[5] = '{
		'{12, KEY_ADD, 13, {2'b00, 16'h09c4, 8'hfe}},
		'{25, KEY_SUB, 13, {2'b00, 16'h04b0, 8'hfe}},
		'{13, KEY_SUB, 25, {2'b10, 16'h04b0, 8'hfe}},
		'{13, KEY_MUL, 3, {2'b00, 16'h0f3c, 8'hfe}},
		'{12, KEY_DIV, 4, {2'b00, 16'h0bb8, 8'hfd}}
	};

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		repeat (20) @(negedge clk);
		chk(x_val, 40'h0);
		chk(cmd_code, KEY_OTHER);
		sys_rst = 1'b0;
		foreach (rows[i]) begin
			num(rows[i].a);
			i_kbd.press(KEY_ENTER, 4'h0);
			num(rows[i].b);
			i_kbd.press(rows[i].op, 4'h0);
			idle(w);
			chk(x_val, rows[i].r);
		end
		// mantissa: extra point, twelve characters, sign, shift
		i_kbd.press(KEY_DIGIT, 4'h1);
		i_kbd.press(KEY_POINT, 4'h0);
		i_kbd.press(KEY_POINT, 4'h0);
		chk(warn, 1'b1);
		repeat (10) i_kbd.press(KEY_DIGIT, 4'h1);
		chk(warn, 1'b0);
		i_kbd.press(KEY_DIGIT, 4'h7);
		chk(warn, 1'b1);
		chk(entry_mant, 40'h2964619c7);
		repeat (3) i_kbd.press(KEY_SIGN_TOGGLE, 4'h0);
		chk(entry_sign, 1'b1);
		i_kbd.press(KEY_RUN, 4'h0);
		chk(cmd_valid, 1'b1);
		chk(cmd_code, KEY_RUN);
		chk(entry_active, 1'b1);
		i_kbd.press(KEY_SHIFT, 4'h0);
		chk(shift_mark, 1'b1);
		@(negedge clk);
		chk(blank_chars, 3'h5);
		i_kbd.press(KEY_CLEAR_SHIFT, 4'h0);
		chk(shift_mark, 1'b0);
		// exponent: last two digits, warnings, own sign
		i_kbd.press(KEY_EXPONENT_ENTRY, 4'h0);
		chk(entry_in_exp, 1'b1);
		for (int d = 1; d <= 3; d++) i_kbd.press(KEY_DIGIT, 4'(d));
		chk(entry_exp_digits, 8'h23);
		i_kbd.press(KEY_POINT, 4'h0);
		chk(warn, 1'b1);
		i_kbd.press(KEY_EXPONENT_ENTRY, 4'h0);
		chk(warn, 1'b1);
		i_kbd.press(KEY_SIGN_TOGGLE, 4'h0);
		chk(entry_exp_sign, 1'b1);
		chk(entry_sign, 1'b1);
		i_kbd.press(KEY_STOP, 4'h0);
		chk(entry_in_exp, 1'b1);
		i_kbd.press(KEY_ENTER, 4'h0);
		idle(w);
		chk(entry_active, 1'b0);
		chk(x_val, {2'b10, 16'h0457, 8'he6});
		chk(disp_letter, 1'b0);
		chk(disp_lead, 2'h1);
		// exponent key alone, then drop back to the previous number
		i_kbd.press(KEY_EXPONENT_ENTRY, 4'h0);
		chk(entry_mant, 40'h1);
		i_kbd.press(KEY_DIGIT, 4'h6);
		i_kbd.press(KEY_ENTER, 4'h0);
		idle(w);
		chk(x_val, {2'b00, 16'h03e8, 8'h03});
		chk(disp_letter, 1'b1);
		chk(disp_exp, 40'h6);
		i_kbd.press(KEY_DROP_ENTRY, 4'h0);
		idle(w);
		chk(x_val, {2'b10, 16'h0457, 8'he6});
		// chain without enter, then divide by zero
		num(9);
		i_kbd.press(KEY_ENTER, 4'h0);
		num(5);
		i_kbd.press(KEY_ADD, 4'h0);
		idle(w);
		num(2);
		idle(w);
		chk(y_val, {2'b00, 16'h0578, 8'hfe});
		i_kbd.press(KEY_DIV, 4'h0);
		idle(w);
		chk(x_val, {2'b00, 16'h1b58, 8'hfd});
		num(0);
		i_kbd.press(KEY_DIV, 4'h0);
		idle(w);
		chk(w, 1'b1);
		chk(x_val, {2'b00, 16'h270f, 8'h7f});
		chk(disp_stars, 1'b1);
		chk(disp_tiny, 1'b0);
		// reset in mid-run drops the entry, the stack and the marker
		num(4);
		i_kbd.press(KEY_SHIFT, 4'h0);
		sys_rst = 1'b1;
		@(negedge clk);
		chk(entry_active, 1'b0);
		chk(shift_mark, 1'b0);
		chk(x_val, 40'h0);
		sys_rst = 1'b0;
		num(3);
		chk(entry_mant, 40'h3);
		complete_run();
	end
endmodule

bind rpn_entry_stack rpn_es_properties i_prop (.clk, .sys_rst, .key_valid,
	.key_code, .busy, .warn, .cmd_valid, .entry_active, .entry_in_exp,
	.entry_sign, .entry_mant, .entry_exp_sign, .shift_mark, .blank_chars,
	.x_val, .y_val, .disp_exp, .disp_letter);
